// file: hdl/ssn_pkg.sv
package ssn_pkg;
  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_SRC_EN = 6'h15;
  localparam logic [5:0] IDX_RSVD = 6'h26;
  localparam logic [5:0] IDX_FLAGS = 6'h27;
  localparam logic [5:0] IDX_COND = 6'h28;
  localparam logic [5:0] IDX_BUF = 6'h29;
  localparam logic [5:0] IDX_ROW = 6'h2B;
  localparam logic [5:0] IDX_WLO = 6'h2C;
  localparam logic [5:0] IDX_WHI = 6'h2D;
  localparam logic [5:0] IDX_DSP = 6'h30;
  localparam logic [5:0] IDX_CMD = 6'h3E;
  localparam logic [5:0] IDX_TEST = 6'h3F;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int EV_N = 5;
  localparam int EV_POR = 4;
  localparam int SRC_N = 4;
  localparam int ROW_PROG_EN = 6;
  localparam int CMD_READ = 0;
  localparam int CMD_PROG = 1;
  localparam int DSP_FLUSH = 2;
  localparam int DSP_SHDW_T = 3;
  localparam int DSP_FIFO_T = 4;
  localparam int DSP_SHDW_P = 5;
  localparam int DSP_FIFO_P = 6;
  localparam int DSP_OOR = 7;
  localparam logic [5:0] ROW_A = 6'h08;
  localparam logic [5:0] ROW_B = 6'h09;
  localparam logic [5:0] ROW_LO = 6'h1E;
  localparam logic [5:0] ROW_HI = 6'h22;
  // ------------------------------------------------------------------
  // Reset values, responses, timing
  // ------------------------------------------------------------------
  localparam logic [7:0] DSP_RST = 8'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int CLK_NS = 4;
  localparam int READBACK_NS = 1000;
  localparam int READBACK_CYC = (READBACK_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic aw_ok;
    logic [5:0] aw_idx;
    logic w_ok;
    logic [7:0] wdata;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [5:0] ar_idx;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [EV_N-1:0] flags;
    logic [SRC_N-1:0] src_en;
    logic nvm_err;
    logic cmd_err;
    logic ecc_fixed;
    logic crack_pass;
    logic crack_req;
    logic [6:0] row;
    logic [7:0] wlo;
    logic [7:0] whi;
    logic [7:0] dsp;
    logic cmd_go;
    logic cmd_prog;
    logic pop;
  } ssn_state_s;
endpackage

// file: hdl/ssn_regs.sv
// Decided for this implementation: the AXI4-Lite slave port.
module ssn_regs
  import ssn_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [EV_N-1:0] event_pulse,
  output logic int_out,
  input wire logic core_ready,
  input wire logic nvm_idle,
  input wire logic nvm_done,
  input wire logic nvm_fault,
  input wire logic nvm_ecc_fixed,
  output logic nvm_cmd_go,
  output logic nvm_cmd_prog,
  output logic [5:0] nvm_row,
  output logic [15:0] nvm_word,
  input wire logic conv_busy,
  input wire logic meas_start,
  input wire logic deep_sleep,
  input wire logic forced_mode,
  output logic nvm_reload,
  output logic iir_flush,
  output logic [1:0] compensation_select,
  output logic shadow_filt_t,
  output logic shadow_filt_p,
  output logic buffer_filt_t,
  output logic buffer_filt_p,
  output logic range_filt_p,
  input wire logic [7:0] buffer_data,
  output logic buffer_pop,
  output logic crack_test_request,
  input wire logic crack_done,
  input wire logic crack_ok
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  ssn_state_s s_r;
  ssn_state_s s_nxt;
  logic wr_go;
  logic rd_go;
  logic [5:0] rd_idx;
  logic row_ok;
  logic [7:0] wd;

  assign rd_idx = araddr[7:2];
  assign wd = s_r.wdata;
  // Rows that a program command may target
  assign row_ok = (s_r.row[5:0] == ROW_A) || (s_r.row[5:0] == ROW_B) ||
                  ((s_r.row[5:0] >= ROW_LO) && (s_r.row[5:0] <= ROW_HI));

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    wr_go = s_r.aw_ok & s_r.w_ok & ~s_r.bvalid;
    rd_go = arvalid & ~s_r.rvalid;
    s_nxt.cmd_go = 1'b0;
    s_nxt.pop = 1'b0;
    if (awvalid & ~s_r.aw_ok) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.aw_idx = awaddr[7:2];
    end
    if (wvalid & ~s_r.w_ok) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.wdata = wdata[7:0];
      s_nxt.wen = wstrb[0];
    end
    if (s_r.bvalid & bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid & rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Sticky events, clear on read of the event byte
    if (rd_go && rd_idx == IDX_FLAGS) begin
      s_nxt.flags = '0;
    end
    s_nxt.flags = s_nxt.flags | event_pulse;
    // Self-test outcome
    if (!s_r.crack_req) begin
      s_nxt.crack_pass = 1'b0;
    end else if (crack_done & crack_ok) begin
      s_nxt.crack_pass = 1'b1;
    end
    // Register writes
    if (wr_go) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (s_r.aw_idx)
        IDX_SRC_EN: begin
          if (s_r.wen) begin
            s_nxt.src_en = wd[SRC_N-1:0];
          end
        end
        IDX_ROW: begin
          if (s_r.wen && !conv_busy) begin
            s_nxt.row = wd[6:0];
          end
        end
        IDX_WLO: begin
          if (s_r.wen && !conv_busy) begin
            s_nxt.wlo = wd;
          end
        end
        IDX_WHI: begin
          if (s_r.wen && !conv_busy) begin
            s_nxt.whi = wd;
          end
        end
        IDX_DSP: begin
          if (s_r.wen && !conv_busy) begin
            s_nxt.dsp = wd;
          end
        end
        IDX_CMD: begin
          if (s_r.wen && (wd[CMD_READ] | wd[CMD_PROG])) begin
            s_nxt.cmd_err = 1'b0;
            s_nxt.ecc_fixed = 1'b0;
            if (!nvm_idle) begin
              s_nxt.cmd_err = 1'b1;
            end else begin
              s_nxt.cmd_go = 1'b1;
              s_nxt.cmd_prog = wd[CMD_PROG];
              s_nxt.nvm_err = 1'b0;
              if (wd[CMD_PROG] && (!s_r.row[ROW_PROG_EN] || !row_ok)) begin
                s_nxt.cmd_err = 1'b1;
              end
            end
          end
        end
        IDX_TEST: begin
          if (s_r.wen) begin
            s_nxt.crack_req = wd[0];
          end
        end
        IDX_RSVD, IDX_FLAGS, IDX_COND, IDX_BUF: begin
          s_nxt.bresp = RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = RESP_DECERR;
        end
      endcase
    end
    // Memory controller results, after the writes so a result beats a same-cycle command clear
    if (nvm_done) begin
      if (nvm_fault) begin
        s_nxt.nvm_err = 1'b1;
      end
      if (nvm_ecc_fixed) begin
        s_nxt.ecc_fixed = 1'b1;
      end
    end
    // Register reads
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.ar_idx = rd_idx;
      s_nxt.rresp = RESP_OKAY;
      case (rd_idx)
        IDX_SRC_EN: s_nxt.rdata = {4'h0, s_r.src_en};
        IDX_RSVD: s_nxt.rdata = 8'h00;
        IDX_FLAGS: s_nxt.rdata = {3'h0, s_r.flags};
        IDX_COND: begin
          s_nxt.rdata = {s_r.crack_pass, 2'h0, s_r.ecc_fixed, s_r.cmd_err,
                         s_r.nvm_err, nvm_idle, core_ready};
        end
        IDX_BUF: begin
          s_nxt.rdata = buffer_data;
          s_nxt.pop = 1'b1;
        end
        IDX_ROW: s_nxt.rdata = {1'b0, s_r.row};
        IDX_WLO: s_nxt.rdata = s_r.wlo;
        IDX_WHI: s_nxt.rdata = s_r.whi;
        IDX_DSP: s_nxt.rdata = s_r.dsp;
        IDX_CMD: s_nxt.rdata = 8'h00;
        IDX_TEST: s_nxt.rdata = {7'h00, s_r.crack_req};
        default: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.dsp <= DSP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign awready = ~s_r.aw_ok;
  assign wready = ~s_r.w_ok;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = ~s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rdata = {24'h000000, s_r.rdata};
  assign rresp = s_r.rresp;
  assign int_out = |(s_r.flags & {1'b1, s_r.src_en});
  assign nvm_cmd_go = s_r.cmd_go;
  assign nvm_cmd_prog = s_r.cmd_prog;
  assign nvm_row = s_r.row[5:0];
  assign nvm_word = {s_r.whi, s_r.wlo};
  assign nvm_reload = meas_start & deep_sleep;
  assign iir_flush = meas_start & forced_mode & s_r.dsp[DSP_FLUSH];
  assign compensation_select = s_r.dsp[1:0];
  assign shadow_filt_t = s_r.dsp[DSP_SHDW_T];
  assign shadow_filt_p = s_r.dsp[DSP_SHDW_P];
  assign buffer_filt_t = s_r.dsp[DSP_FIFO_T];
  assign buffer_filt_p = s_r.dsp[DSP_FIFO_P];
  assign range_filt_p = s_r.dsp[DSP_OOR];
  assign buffer_pop = s_r.pop;
  assign crack_test_request = s_r.crack_req;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  flag_clear_a: assert property (rd_go && rd_idx == IDX_FLAGS && event_pulse == '0 |=> s_r.flags == '0)
    else $error("event byte not cleared by read");
  set_wins_a: assert property (rd_go && rd_idx == IDX_FLAGS && event_pulse[0] |=> s_r.flags[0])
    else $error("event lost during clearing read");
  rsvd_zero_a: assert property (rd_go && rd_idx == IDX_RSVD |=> rvalid && rdata == 32'h00000000)
    else $error("reserved byte not zero");
  por_irq_a: assert property (event_pulse[EV_POR] |=> int_out)
    else $error("reset-done event did not raise interrupt");
  busy_block_a: assert property (wr_go && s_r.aw_idx == IDX_DSP && conv_busy |=> $stable(s_r.dsp))
    else $error("setup written during conversion");
  cmd_busy_a: assert property (wr_go && s_r.aw_idx == IDX_CMD && s_r.wen && wd[CMD_READ]
                               && !nvm_idle && !nvm_done |=> s_r.cmd_err && !nvm_cmd_go && $stable(s_r.nvm_err))
    else $error("busy command not refused");
  bad_row_a: assert property (wr_go && s_r.aw_idx == IDX_CMD && s_r.wen && wd[CMD_PROG] && nvm_idle
                              && !row_ok |=> s_r.cmd_err && nvm_cmd_go)
    else $error("bad row not flagged");
  crack_clear_a: assert property (!s_r.crack_req |=> !s_r.crack_pass)
    else $error("crack pass kept without request");
  buf_pop_a: assert property (rd_go && rd_idx == IDX_BUF |=> buffer_pop ##1 !buffer_pop)
    else $error("buffer pop not one pulse");

  // ------------------------------------------------------------------
  // Status, memory command, buffer and register access checks
  // ------------------------------------------------------------------
  cond_core_a: assert property (rd_go && rd_idx == IDX_COND |=> rdata[0] == $past(core_ready))
    else $error("core bit does not follow core ready");
  cond_idle_a: assert property (rd_go && rd_idx == IDX_COND |=> rdata[1] == $past(nvm_idle))
    else $error("idle bit does not follow controller");
  fault_set_a: assert property (nvm_done && nvm_fault |=> s_r.nvm_err)
    else $error("memory fault not recorded");
  err_hold_a: assert property (!nvm_done && !(wr_go && s_r.aw_idx == IDX_CMD) |=> $stable(s_r.nvm_err))
    else $error("memory fault bit changed without command");
  cmd_clear_a: assert property (wr_go && s_r.aw_idx == IDX_CMD && s_r.wen && wd[CMD_READ]
                                && !wd[CMD_PROG] && nvm_idle && !nvm_done |=> !s_r.nvm_err && !s_r.cmd_err && nvm_cmd_go)
    else $error("read command did not clear errors");
  prog_off_a: assert property (wr_go && s_r.aw_idx == IDX_CMD && s_r.wen && wd[CMD_PROG] && nvm_idle
                               && !s_r.row[ROW_PROG_EN] |=> s_r.cmd_err && nvm_cmd_go && nvm_cmd_prog)
    else $error("disabled program not flagged");
  cmd_err_hold_a: assert property (!(wr_go && s_r.aw_idx == IDX_CMD) |=> $stable(s_r.cmd_err))
    else $error("command error changed without command");
  ecc_set_a: assert property (nvm_done && nvm_ecc_fixed |=> s_r.ecc_fixed)
    else $error("ECC correction not recorded");
  ecc_clear_a: assert property (wr_go && s_r.aw_idx == IDX_CMD && (wd[CMD_READ] || wd[CMD_PROG])
                                && s_r.wen && !nvm_done |=> !s_r.ecc_fixed)
    else $error("ECC bit kept over new command");
  ecc_hold_a: assert property (!nvm_done && !(wr_go && s_r.aw_idx == IDX_CMD) |=> $stable(s_r.ecc_fixed))
    else $error("ECC bit changed without command");
  crack_set_a: assert property (s_r.crack_req && crack_done && crack_ok |=> s_r.crack_pass)
    else $error("passed crack check not recorded");
  buf_data_a: assert property (rd_go && rd_idx == IDX_BUF |=> rdata[7:0] == $past(buffer_data))
    else $error("buffer byte not returned");
  pop_idle_a: assert property (!(rd_go && rd_idx == IDX_BUF) |=> !buffer_pop)
    else $error("buffer popped without read");
  row_read_a: assert property (rd_go && rd_idx == IDX_ROW |=> rdata[7:0] == {1'b0, $past(s_r.row)})
    else $error("row byte read back wrong");
  flags_read_a: assert property (rd_go && rd_idx == IDX_FLAGS |=> rdata[7:5] == 3'h0)
    else $error("reserved event bits not zero");
  word_hold_a: assert property (wr_go && (s_r.aw_idx == IDX_WLO || s_r.aw_idx == IDX_WHI) && conv_busy
                                |=> $stable(nvm_word))
    else $error("memory word written during conversion");
  row_hold_a: assert property (wr_go && s_r.aw_idx == IDX_ROW && conv_busy |=> $stable(s_r.row))
    else $error("row written during conversion");
  dsp_write_a: assert property (wr_go && s_r.aw_idx == IDX_DSP && s_r.wen && !conv_busy
                                |=> s_r.dsp == $past(wd))
    else $error("setup byte not written");
  go_idle_a: assert property (!(wr_go && s_r.aw_idx == IDX_CMD) |=> !nvm_cmd_go)
    else $error("memory command issued without request");
  flags_hold_a: assert property (!(rd_go && rd_idx == IDX_FLAGS)
                                 |=> (s_r.flags | $past(s_r.flags)) == s_r.flags)
    else $error("event flag dropped without read");
endmodule

// file: tb/ssn_nvm_model.sv
module ssn_nvm_model #(
  parameter int DLY = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nvm_cmd_go,
  input wire logic buffer_pop,
  input wire logic fault_in,
  input wire logic ecc_in,
  output logic nvm_idle,
  output logic nvm_done,
  output logic nvm_fault,
  output logic nvm_ecc_fixed,
  output logic [7:0] buffer_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Controller and sample buffer far side
  // ------------------------------------------------------------
  int cnt;
  always @(posedge aclk) begin
    nvm_done <= 1'b0;
    if (!aresetn) begin
      cnt <= 0;
      buffer_data <= 8'h40;
    end else begin
      if (buffer_pop) buffer_data <= buffer_data + 8'h01;
      if (nvm_cmd_go) cnt <= DLY;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) nvm_done <= 1'b1;
    end
  end
  assign nvm_idle = (cnt == 0);
  // Qualifiers are only meaningful with done; otherwise show the inverse
  assign nvm_fault = nvm_done ? fault_in : ~fault_in;
  assign nvm_ecc_fixed = nvm_done ? ecc_in : ~ecc_in;
endmodule

// file: tb/tb_sensor_status_nvm_dsp_regs.sv
module tb_sensor_status_nvm_dsp_regs;
  import ssn_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [5:0] i; logic [7:0] w; logic [1:0] r; logic [7:0] v;} ssn_row_s;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, buffer_data;
  logic [31:0] wdata = 0, rdata;
  logic [4:0] event_pulse = 0;
  logic core_ready = 0, conv_busy = 0, meas_start = 0, deep_sleep = 0, forced_mode = 0;
  logic crack_done = 0, crack_ok = 0, fault_in = 0, ecc_in = 0;
  logic awready, wready, bvalid, arready, rvalid, int_out, nvm_idle, nvm_done, nvm_fault, nvm_ecc_fixed;
  logic nvm_cmd_go, nvm_cmd_prog, nvm_reload, iir_flush, buffer_pop, crack_test_request;
  logic shadow_filt_t, shadow_filt_p, buffer_filt_t, buffer_filt_p, range_filt_p;
  logic [1:0] bresp, rresp, compensation_select;
  logic [5:0] nvm_row;
  logic [15:0] nvm_word;
  int err_count = 0, n_tests = 0, cyc = 0;
  ssn_row_s rows [9] = '{'{IDX_RSVD, 8'hFF, RESP_OKAY, 8'h00}, '{IDX_FLAGS, 8'hFF, RESP_OKAY, 8'h00},
    '{IDX_COND, 8'hFF, RESP_OKAY, 8'h02}, '{IDX_ROW, 8'hFF, RESP_OKAY, 8'h7F},
    '{IDX_WLO, 8'hA5, RESP_OKAY, 8'hA5}, '{IDX_WHI, 8'h5A, RESP_OKAY, 8'h5A},
    '{IDX_DSP, 8'hF8, RESP_OKAY, 8'hF8}, '{IDX_DSP, 8'h07, RESP_OKAY, 8'h07},
    '{6'h01, 8'h11, RESP_DECERR, 8'h00}};
  logic [7:0] prow [6] = '{8'h48, 8'h4A, 8'h5E, 8'h63, 8'h1E, 8'h49};
  logic [7:0] pexp [6] = '{8'h03, 8'h0B, 8'h03, 8'h0B, 8'h0B, 8'h03};

  ssn_regs uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .event_pulse(event_pulse),
    .int_out(int_out), .core_ready(core_ready), .nvm_idle(nvm_idle), .nvm_done(nvm_done),
    .nvm_fault(nvm_fault), .nvm_ecc_fixed(nvm_ecc_fixed), .nvm_cmd_go(nvm_cmd_go),
    .nvm_cmd_prog(nvm_cmd_prog), .nvm_row(nvm_row), .nvm_word(nvm_word), .conv_busy(conv_busy),
    .meas_start(meas_start), .deep_sleep(deep_sleep), .forced_mode(forced_mode), .nvm_reload(nvm_reload),
    .iir_flush(iir_flush), .compensation_select(compensation_select), .shadow_filt_t(shadow_filt_t),
    .shadow_filt_p(shadow_filt_p), .buffer_filt_t(buffer_filt_t), .buffer_filt_p(buffer_filt_p),
    .range_filt_p(range_filt_p), .buffer_data(buffer_data), .buffer_pop(buffer_pop),
    .crack_test_request(crack_test_request), .crack_done(crack_done), .crack_ok(crack_ok));
  ssn_nvm_model mdl (.aclk(aclk), .aresetn(aresetn), .nvm_cmd_go(nvm_cmd_go), .buffer_pop(buffer_pop),
    .fault_in(fault_in), .ecc_in(ecc_in), .nvm_idle(nvm_idle), .nvm_done(nvm_done), .nvm_fault(nvm_fault),
    .nvm_ecc_fixed(nvm_ecc_fixed), .buffer_data(buffer_data));

  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_count++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // Verdict, check, bus, event and wait tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic a, w, ad, wd, ok;
    logic [1:0] r;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    do begin
      @(negedge aclk);
      a = awready & ~ad;
      w = wready & ~wd;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      ad = ad | a;
      wd = wd | w;
    end while (!(ad && wd));
    do begin
      @(negedge aclk);
      ok = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!ok);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] ev, input logic [1:0] er = RESP_OKAY);
    logic ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= {i, 2'b00};
    do begin
      @(negedge aclk);
      ok = arready;
      @(posedge aclk);
    end while (!ok);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!ok);
    rready <= 1'b0;
    chk(d, {24'h0, ev});
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic pulse(input logic [4:0] e);
    @(posedge aclk);
    event_pulse <= e;
    @(posedge aclk);
    event_pulse <= 5'h00;
    @(negedge aclk);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge aclk);
    while (!nvm_idle) @(posedge aclk);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].i, rows[k].w, rows[k].r);
      repeat (READBACK_CYC) @(posedge aclk);
      rd(rows[k].i, rows[k].v, rows[k].r);
      if (rows[k].i == IDX_DSP) chk({range_filt_p, buffer_filt_p, shadow_filt_p, buffer_filt_t, shadow_filt_t,
        compensation_select}, {rows[k].v[7:3], rows[k].v[1:0]});
    end
    chk(nvm_word, 16'h5AA5);
    chk(nvm_row, 6'h3F);
    $display("table done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_DSP, DSP_RST);
    rd(IDX_COND, 8'h02);
    core_ready <= 1'b1;
    rd(IDX_COND, 8'h03);
    $display("reset done");
    pulse(5'h01);
    chk(int_out, 1'b0);
    pulse(5'h10);
    chk(int_out, 1'b1);
    rd(IDX_FLAGS, 8'h11);
    rd(IDX_FLAGS, 8'h00);
    pulse(5'h1F);
    rd(IDX_FLAGS, 8'h1F);
    wr(IDX_SRC_EN, 8'h01);
    pulse(5'h01);
    chk(int_out, 1'b1);
    rd(IDX_FLAGS, 8'h01);
    fork
      rd(IDX_FLAGS, 8'h00);
      pulse(5'h01);
    join
    rd(IDX_FLAGS, 8'h01);
    $display("events done");
    conv_busy <= 1'b1;
    wr(IDX_DSP, 8'h00);
    wr(IDX_ROW, 8'h01);
    rd(IDX_DSP, 8'h03);
    rd(IDX_ROW, 8'h00);
    wr(IDX_WLO, 8'hFF);
    rd(IDX_WLO, 8'h00);
    conv_busy <= 1'b0;
    foreach (prow[k]) begin
      wr(IDX_ROW, prow[k]);
      wr(IDX_CMD, 8'h02);
      chk(nvm_cmd_prog, 1'b1);
      wait_idle();
      rd(IDX_COND, pexp[k]);
    end
    fault_in <= 1'b1;
    wr(IDX_CMD, 8'h01);
    chk(nvm_cmd_prog, 1'b0);
    wr(IDX_CMD, 8'h01);
    wait_idle();
    rd(IDX_COND, 8'h0F);
    fault_in <= 1'b0;
    ecc_in <= 1'b1;
    wr(IDX_CMD, 8'h01);
    wait_idle();
    ecc_in <= 1'b0;
    rd(IDX_COND, 8'h13);
    $display("memory done");
    rd(IDX_BUF, 8'h40);
    rd(IDX_BUF, 8'h41);
    wr(IDX_TEST, 8'h01);
    chk(crack_test_request, 1'b1);
    crack_ok <= 1'b1;
    crack_done <= 1'b1;
    @(posedge aclk);
    crack_done <= 1'b0;
    rd(IDX_COND, 8'h93);
    wr(IDX_TEST, 8'h00);
    rd(IDX_COND, 8'h13);
    {meas_start, forced_mode, deep_sleep} <= 3'b111;
    @(negedge aclk);
    chk(iir_flush, 1'b0);
    @(posedge aclk);
    meas_start <= 1'b0;
    wr(IDX_DSP, 8'h04);
    meas_start <= 1'b1;
    @(negedge aclk);
    chk(iir_flush, 1'b1);
    chk(nvm_reload, 1'b1);
    @(posedge aclk);
    {meas_start, deep_sleep} <= 2'b10;
    @(negedge aclk);
    chk(nvm_reload, 1'b0);
    chk(iir_flush, 1'b1);
    @(posedge aclk);
    meas_start <= 1'b0;
    $display("misc done");
    give_verdict();
  end
endmodule
